// file: rtl/ursc_defines.svh
`ifndef URSC_DEFINES_SVH
`define URSC_DEFINES_SVH
// ==========================================================
// register byte offsets
`define URSC_OFS_CTRL 8'h00
`define URSC_OFS_CMD 8'h04
`define URSC_OFS_STATUS 8'h08
`define URSC_OFS_RXDATA 8'h0c
`define URSC_OFS_RXDIV 8'h10
`define URSC_OFS_TXDIV 8'h14
`define URSC_OFS_FORMAT 8'h18
// ==========================================================
// control register fields
`define URSC_CTRL_LEN1 0
`define URSC_CTRL_LEN2 1
`define URSC_CTRL_PINH 2
`define URSC_CTRL_EVEN 3
`define URSC_CTRL_STOP 4
`define URSC_CTRL_LOAD 5
`define URSC_CTRL_MCLR 6
`define URSC_CTRL_SFD 7
`define URSC_CTRL_W 8
// command register fields
`define URSC_CMD_FLAG_CLR 0
// status register fields
`define URSC_ST_DR 0
`define URSC_ST_OE 1
`define URSC_ST_FE 2
`define URSC_ST_PE 3
`define URSC_ST_TBE 4
`define URSC_ST_TSE 5
`define URSC_ST_BUSY 6
// ==========================================================
// reset values
`define URSC_CTRL_RST 8'h23
`define URSC_FMT_RST 5'h03
`define URSC_RXDIV_RST 16'h0516
`define URSC_TXDIV_RST 16'h0516
// ==========================================================
// timing counts
`define URSC_TSE_DELAY 5'h12
`define URSC_OVS_MID 5'h07
`define URSC_OVS_LAST 5'h0f
`define URSC_STOP_EXTRA_HALF 5'h08
`define URSC_STOP_EXTRA_FULL 5'h10
`endif

// file: rtl/ursc_pkg.sv
// ==========================================================
// shared types
package ursc_pkg;
  // receiver sequence
  typedef enum logic [2:0] {
    URSC_IDLE,
    URSC_START,
    URSC_DATA,
    URSC_PARITY,
    URSC_STOP,
    URSC_HOLD
  } ursc_rx_state_t;
  // active character format
  typedef struct packed {
    logic stop_select;
    logic even_parity_enable;
    logic parity_inhibit;
    logic length_select_two;
    logic length_select_one;
  } ursc_fmt_t;
endpackage : ursc_pkg

// file: rtl/ursc_tick_if.sv
`timescale 1ns/1ps
// ==========================================================
// divisor and enable pulse between divider and user
interface ursc_tick_if #(parameter int DIV_W = 16);
  logic [DIV_W-1:0] divisor; // cycles per tick
  logic tick; // one-cycle enable pulse
  modport src (input divisor, output tick);
  modport use_side (output divisor, input tick);
endinterface : ursc_tick_if

// file: rtl/ursc_tick_div.sv
`timescale 1ns/1ps
// ==========================================================
// clock divider: one enable pulse every divisor cycles
module ursc_tick_div #(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  ursc_tick_if.src bus
);
  import ursc_pkg::*;
  logic [DIV_W-1:0] cnt_reg; // cycles since last tick
  logic [DIV_W-1:0] cnt_next;
  logic tick_reg; // registered pulse
  logic tick_next;
  // a divisor of zero behaves like one so the tick never dies
  if (DIV_W < 2 || DIV_W > 32)
  begin : g_bad_div_w
    $error("ursc_tick_div: DIV_W out of range");
  end
  // ========================================================
  // next count
  always_comb
  begin
    cnt_next = cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
    tick_next = 1'b0;
    if (cnt_next >= bus.divisor)
    begin
      // wrap and emit one pulse
      cnt_next = '0;
      tick_next = 1'b1;
    end
  end
  // registers only
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end
  assign bus.tick = tick_reg;
endmodule : ursc_tick_div

// file: rtl/ursc_sync3.sv
`timescale 1ns/1ps
// ==========================================================
// three-stage synchroniser; output moves once stages 2 and 3 agree
module ursc_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic async_in,
  output logic sync_out
);
  logic s1_reg; // metastable stage, read only by s2
  logic s2_reg;
  logic s3_reg;
  logic out_reg; // filtered level
  logic out_next;
  // ========================================================
  // the agree test filters single-cycle glitches on the pin
  always_comb
  begin
    out_next = out_reg;
    if (s2_reg == s3_reg)
    begin
      out_next = s3_reg;
    end
  end
  // registers only
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      out_reg <= RST_VAL;
    end
    else
    begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end
  assign sync_out = out_reg;
endmodule : ursc_sync3

// file: rtl/ursc_top.sv
`timescale 1ns/1ps
`include "ursc_defines.svh"
// Contract
// - flag disable releases status flag pins
// - low flag clear forces data received low except in a buffer transfer cycle
// - data received rises on buffer transfer
// - serial input shifted using receive ticks
// - master clear holds error flags low
// - shift empty rises 18 transmit ticks after master clear falls
// - master clear keeps receiver buffer contents
// - config load copies format inputs
// - stop select lengthens the stop period
// - length bits pick size; one gives six
// - even or odd parity per enable
// - overrun when previous character unread
module ursc_top
  import ursc_pkg::*;
#(
  parameter int DIV_W = 16,
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_serial_in,
  output logic [DATA_W-1:0] rx_data,
  output logic parity_error,
  output logic framing_error,
  output logic overrun_error,
  output logic data_received,
  output logic tx_buffer_empty,
  output logic status_flags_oe,
  output logic tx_shift_empty
);
  // refused at elaboration: the receiver indexes exactly eight data bits
  if (DATA_W != 8 || DIV_W < 2 || DIV_W > 16)
  begin : g_bad_params
    $error("ursc_top: unsupported DATA_W or DIV_W");
  end
  // ========================================================
  // dividers: receive 16x tick and independent transmit tick
  ursc_tick_if #(.DIV_W(DIV_W)) rx_bit_clock ();
  ursc_tick_if #(.DIV_W(DIV_W)) tx_bit_clock ();
  ursc_tick_div #(.DIV_W(DIV_W)) u_rx_div (
    .clk(clk),
    .arst_n(arst_n),
    .bus(rx_bit_clock.src)
  );
  ursc_tick_div #(.DIV_W(DIV_W)) u_tx_div (
    .clk(clk),
    .arst_n(arst_n),
    .bus(tx_bit_clock.src)
  );
  // serial line after the pin filter
  logic rx_line;
  ursc_sync3 #(.RST_VAL(1'b1)) u_rx_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(rx_serial_in),
    .sync_out(rx_line)
  );
  // ========================================================
  // apb slave and software registers
  logic [`URSC_CTRL_W-1:0] ctrl_reg; // raw format, load, clear, disable
  logic [`URSC_CTRL_W-1:0] ctrl_next;
  logic [DIV_W-1:0] rxdiv_reg; // cycles per receive tick
  logic [DIV_W-1:0] rxdiv_next;
  logic [DIV_W-1:0] txdiv_reg; // cycles per transmit tick
  logic [DIV_W-1:0] txdiv_next;
  logic [31:0] rdata_reg; // captured in the setup cycle
  logic [31:0] rdata_next;
  logic flag_clr_n_reg; // active-low flag clear pulse
  logic flag_clr_n_next;
  logic wr_en; // write takes effect at the access edge
  logic hit; // address maps to a register
  logic [31:0] status_word;
  ursc_fmt_t fmt_reg; // active control register
  ursc_fmt_t fmt_next;
  logic master_clear;
  assign master_clear = ctrl_reg[`URSC_CTRL_MCLR];
  assign rx_bit_clock.divisor = rxdiv_reg;
  assign tx_bit_clock.divisor = txdiv_reg;
  assign wr_en = psel && penable && pwrite;
  // zero wait states: the read word is ready from the setup cycle
  assign pready = psel && penable;
  assign pslverr = psel && penable && !hit;
  assign prdata = rdata_reg;
  // address decode
  always_comb
  begin
    case (paddr)
      `URSC_OFS_CTRL, `URSC_OFS_CMD, `URSC_OFS_STATUS, `URSC_OFS_RXDATA,
      `URSC_OFS_RXDIV, `URSC_OFS_TXDIV, `URSC_OFS_FORMAT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  // register writes and read capture
  always_comb
  begin
    ctrl_next = ctrl_reg;
    rxdiv_next = rxdiv_reg;
    txdiv_next = txdiv_reg;
    rdata_next = rdata_reg;
    flag_clr_n_next = 1'b1;
    if (wr_en)
    begin
      case (paddr)
        `URSC_OFS_CTRL: ctrl_next = pwdata[`URSC_CTRL_W-1:0];
        // a one on the clear bit gives one low cycle
        `URSC_OFS_CMD: flag_clr_n_next = !pwdata[`URSC_CMD_FLAG_CLR];
        `URSC_OFS_RXDIV: rxdiv_next = pwdata[DIV_W-1:0];
        `URSC_OFS_TXDIV: txdiv_next = pwdata[DIV_W-1:0];
        default: ctrl_next = ctrl_reg;
      endcase
    end
    if (psel && !penable && !pwrite)
    begin
      // unmapped and write-only addresses read as zero
      case (paddr)
        `URSC_OFS_CTRL: rdata_next = {{(32-`URSC_CTRL_W){1'b0}}, ctrl_reg};
        `URSC_OFS_STATUS: rdata_next = status_word;
        `URSC_OFS_RXDATA: rdata_next = {{(32-DATA_W){1'b0}}, rx_data};
        `URSC_OFS_RXDIV: rdata_next = {{(32-DIV_W){1'b0}}, rxdiv_reg};
        `URSC_OFS_TXDIV: rdata_next = {{(32-DIV_W){1'b0}}, txdiv_reg};
        `URSC_OFS_FORMAT: rdata_next = {27'h0, fmt_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end
  // copy the format while load is high; a held load tracks it
  always_comb
  begin
    fmt_next = fmt_reg;
    if (ctrl_reg[`URSC_CTRL_LOAD])
    begin
      fmt_next.length_select_one = ctrl_reg[`URSC_CTRL_LEN1];
      fmt_next.length_select_two = ctrl_reg[`URSC_CTRL_LEN2];
      fmt_next.parity_inhibit = ctrl_reg[`URSC_CTRL_PINH];
      fmt_next.even_parity_enable = ctrl_reg[`URSC_CTRL_EVEN];
      fmt_next.stop_select = ctrl_reg[`URSC_CTRL_STOP];
    end
  end
  // registers only
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_reg <= `URSC_CTRL_RST;
      rxdiv_reg <= DIV_W'(`URSC_RXDIV_RST);
      txdiv_reg <= DIV_W'(`URSC_TXDIV_RST);
      rdata_reg <= 32'h00000000;
      flag_clr_n_reg <= 1'b1;
      fmt_reg <= `URSC_FMT_RST;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      rxdiv_reg <= rxdiv_next;
      txdiv_reg <= txdiv_next;
      rdata_reg <= rdata_next;
      flag_clr_n_reg <= flag_clr_n_next;
      fmt_reg <= fmt_next;
    end
  end
  // ========================================================
  // receiver sequence on the 16x tick
  ursc_rx_state_t st_reg; // receiver state
  ursc_rx_state_t st_next;
  logic [4:0] cnt_reg; // ticks inside the current bit
  logic [4:0] cnt_next;
  logic [2:0] idx_reg; // data bit position, lsb first
  logic [2:0] idx_next;
  logic [DATA_W-1:0] shift_reg; // receiver shift register
  logic [DATA_W-1:0] shift_next;
  logic par_reg; // sampled parity bit
  logic par_next;
  logic xfer; // character moves into the buffer this cycle
  logic [2:0] last_idx; // index of the final data bit
  logic [4:0] stop_extra; // ticks after mid of first stop
  logic par_bad;
  // 5, 6, 7 and 8 bits end at index 4, 5, 6 and 7
  assign last_idx = {1'b1, fmt_reg.length_select_two,
                     fmt_reg.length_select_one};
  // long stop: half bit more for 5-bit, whole bit more otherwise
  always_comb
  begin
    if (!fmt_reg.stop_select)
    begin
      stop_extra = 5'h00;
    end
    else if (!fmt_reg.length_select_one && !fmt_reg.length_select_two)
    begin
      stop_extra = `URSC_STOP_EXTRA_HALF;
    end
    else
    begin
      stop_extra = `URSC_STOP_EXTRA_FULL;
    end
  end
  // even: ones plus parity even; odd: the opposite
  assign par_bad = !fmt_reg.parity_inhibit &&
                   ((^shift_reg ^ par_reg) == fmt_reg.even_parity_enable);
  // next state; unused high data bits stay zero from the start bit
  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    idx_next = idx_reg;
    shift_next = shift_reg;
    par_next = par_reg;
    xfer = 1'b0;
    if (master_clear)
    begin
      st_next = URSC_IDLE;
    end
    else
    begin
      case (st_reg)
        URSC_IDLE:
        begin
          if (!rx_line)
          begin
            st_next = URSC_START;
            cnt_next = 5'h00;
          end
        end
        URSC_START:
        begin
          if (rx_bit_clock.tick)
          begin
            if (cnt_reg == `URSC_OVS_MID)
            begin
              // a start bit gone high by mid-bit was noise
              st_next = rx_line ? URSC_IDLE : URSC_DATA;
              cnt_next = 5'h00;
              idx_next = 3'h0;
              shift_next = '0;
            end
            else
            begin
              cnt_next = cnt_reg + 5'h01;
            end
          end
        end
        URSC_DATA:
        begin
          if (rx_bit_clock.tick)
          begin
            if (cnt_reg == `URSC_OVS_LAST)
            begin
              shift_next[idx_reg] = rx_line;
              cnt_next = 5'h00;
              idx_next = idx_reg + 3'h1;
              if (idx_reg == last_idx)
              begin
                st_next = fmt_reg.parity_inhibit ? URSC_STOP : URSC_PARITY;
              end
            end
            else
            begin
              cnt_next = cnt_reg + 5'h01;
            end
          end
        end
        URSC_PARITY:
        begin
          if (rx_bit_clock.tick)
          begin
            if (cnt_reg == `URSC_OVS_LAST)
            begin
              par_next = rx_line;
              cnt_next = 5'h00;
              st_next = URSC_STOP;
            end
            else
            begin
              cnt_next = cnt_reg + 5'h01;
            end
          end
        end
        URSC_STOP:
        begin
          if (rx_bit_clock.tick)
          begin
            if (cnt_reg == `URSC_OVS_LAST)
            begin
              // hand over at mid stop, then sit out the rest
              xfer = 1'b1;
              cnt_next = 5'h00;
              st_next = (stop_extra == 5'h00) ? URSC_IDLE : URSC_HOLD;
            end
            else
            begin
              cnt_next = cnt_reg + 5'h01;
            end
          end
        end
        URSC_HOLD:
        begin
          if (rx_bit_clock.tick)
          begin
            cnt_next = cnt_reg + 5'h01;
            if (cnt_next >= stop_extra)
            begin
              st_next = URSC_IDLE;
            end
          end
        end
        default:
        begin
          st_next = URSC_IDLE;
        end
      endcase
    end
  end
  // registers only
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= URSC_IDLE;
      cnt_reg <= 5'h00;
      idx_reg <= 3'h0;
      shift_reg <= '0;
      par_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      idx_reg <= idx_next;
      shift_reg <= shift_next;
      par_reg <= par_next;
    end
  end
  // ========================================================
  // buffer, flags and transmitter-empty timing
  logic [DATA_W-1:0] buf_reg; // receiver buffer register
  logic [DATA_W-1:0] buf_next;
  logic dr_reg, oe_reg, fe_reg, pe_reg, tbe_reg, tse_reg;
  logic dr_next, oe_next, fe_next, pe_next, tbe_next, tse_next;
  logic sfd_reg; // pin release, registered so the enable is clean
  logic [4:0] tse_cnt_reg; // transmit ticks since master clear fell
  logic [4:0] tse_cnt_next;
  always_comb
  begin
    buf_next = xfer ? shift_reg : buf_reg;
    dr_next = dr_reg;
    oe_next = oe_reg;
    fe_next = fe_reg;
    pe_next = pe_reg;
    tbe_next = tbe_reg;
    tse_next = tse_reg;
    tse_cnt_next = tse_cnt_reg;
    if (master_clear)
    begin
      // master clear outranks a transfer
      dr_next = 1'b0;
      oe_next = 1'b0;
      fe_next = 1'b0;
      pe_next = 1'b0;
      tbe_next = 1'b1;
      tse_next = 1'b0;
      tse_cnt_next = 5'h00;
    end
    else
    begin
      if (!flag_clr_n_reg)
      begin
        dr_next = 1'b0;
      end
      if (xfer)
      begin
        // set wins over a clear in the same cycle
        dr_next = 1'b1;
        oe_next = dr_reg;
        fe_next = !rx_line;
        pe_next = par_bad;
      end
      if (!tse_reg && tx_bit_clock.tick)
      begin
        tse_cnt_next = tse_cnt_reg + 5'h01;
        if (tse_cnt_next == `URSC_TSE_DELAY)
        begin
          tse_next = 1'b1;
        end
      end
    end
  end
  // registers only; buffer has no reset term besides power-on
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      buf_reg <= '0;
      dr_reg <= 1'b0;
      oe_reg <= 1'b0;
      fe_reg <= 1'b0;
      pe_reg <= 1'b0;
      tbe_reg <= 1'b1;
      tse_reg <= 1'b0;
      tse_cnt_reg <= 5'h00;
      sfd_reg <= 1'b0;
    end
    else
    begin
      buf_reg <= buf_next;
      dr_reg <= dr_next;
      oe_reg <= oe_next;
      fe_reg <= fe_next;
      pe_reg <= pe_next;
      tbe_reg <= tbe_next;
      tse_reg <= tse_next;
      tse_cnt_reg <= tse_cnt_next;
      sfd_reg <= ctrl_next[`URSC_CTRL_SFD];
    end
  end
  assign status_word = {25'h0, (st_reg != URSC_IDLE), tse_reg, tbe_reg,
                        pe_reg, fe_reg, oe_reg, dr_reg};
  assign rx_data = buf_reg;
  assign parity_error = pe_reg;
  assign framing_error = fe_reg;
  assign overrun_error = oe_reg;
  assign data_received = dr_reg;
  assign tx_buffer_empty = tbe_reg;
  assign tx_shift_empty = tse_reg;
  // outside logic resolves the flag pins to high impedance
  assign status_flags_oe = !sfd_reg;
endmodule : ursc_top

// file: verif/ursc_serial_station.sv
`timescale 1ns/1ps
// ==========================================================
// remote serial station: sends one framed character on demand
module ursc_serial_station #(
  parameter int BIT_CYC = 64 // clk cycles per bit
) (
  input wire logic clk,
  output logic line
);
  // mark level between frames
  initial line = 1'b1;
  // ==========================================================
  // frame: start, data lsb first, optional parity, stop, idle gap
  task automatic send(input logic [7:0] d, input int n, input logic par_on,
    input logic even, input logic par_bad, input int halves, input logic stop_bad);
    logic p;
    p = ^(d & ((8'h01 << n) - 8'h01)) ^ ~even ^ par_bad;
    line <= 1'b0;
    repeat (BIT_CYC) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      line <= d[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    // parity bit only while not inhibited
    if (par_on)
    begin
      line <= p;
      repeat (BIT_CYC) @(posedge clk);
    end
    // a broken stop is released early so no false start follows
    line <= ~stop_bad;
    repeat (BIT_CYC * 3 / 4) @(posedge clk);
    line <= 1'b1;
    repeat (BIT_CYC * (halves + 4) / 2 - BIT_CYC * 3 / 4) @(posedge clk);
  endtask : send
endmodule : ursc_serial_station

// file: verif/ursc_top_monitor.sv
`timescale 1ns/1ps
// ==========================================================
// port checker for the receiver status block
module ursc_top_monitor #(
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [DATA_W-1:0] rx_data,
  input wire logic parity_error,
  input wire logic framing_error,
  input wire logic overrun_error,
  input wire logic data_received,
  input wire logic status_flags_oe,
  input wire logic tx_shift_empty
);
  logic wr_hit; // write lands at this edge
  logic [7:0] ctrl_reg; // shadow of the control word
  logic [15:0] txdiv_reg; // shadow of the transmit divisor
  int unsigned since_reg; // cycles since master clear dropped
  assign wr_hit = psel && penable && pwrite;
  // ==========================================================
  // shadows follow the bus writes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_reg <= 8'h23;
      txdiv_reg <= 16'h0516;
      since_reg <= 0;
    end
    else
    begin
      if (wr_hit && paddr == 8'h00) ctrl_reg <= pwdata[7:0];
      if (wr_hit && paddr == 8'h14) txdiv_reg <= pwdata[15:0];
      since_reg <= ctrl_reg[6] ? 0 : since_reg + 1;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_flag_disable;
    wr_hit && paddr == 8'h00 |=> status_flags_oe == !$past(pwdata[7]);
  endproperty
  a_flag_disable: assert property (p_flag_disable) else $error("pin enable wrong");
  property p_flag_clear;
    wr_hit && paddr == 8'h04 && pwdata[0] |-> ##2 !data_received;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("received flag kept");
  property p_new_data;
    $changed(rx_data) |-> data_received;
  endproperty
  a_new_data: assert property (p_new_data) else $error("buffer moved silently");
  property p_master_clear;
    ctrl_reg[6] && $past(ctrl_reg[6]) |-> !(data_received || parity_error ||
      framing_error || overrun_error || tx_shift_empty);
  endproperty
  a_master_clear: assert property (p_master_clear) else $error("flag up in clear");
  property p_keep_buffer;
    ctrl_reg[6] && $past(ctrl_reg[6]) |-> $stable(rx_data);
  endproperty
  a_keep_buffer: assert property (p_keep_buffer) else $error("buffer lost");
  property p_shift_empty;
    $rose(tx_shift_empty) |-> since_reg >= 17 * txdiv_reg && since_reg <= 18 * txdiv_reg + 4;
  endproperty
  a_shift_empty: assert property (p_shift_empty) else $error("shift empty mistimed");
  property p_overrun;
    $rose(overrun_error) |-> $past(data_received);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun without unread data");
  property p_no_parity;
    ctrl_reg[2] && ctrl_reg[5] && $stable(ctrl_reg) |=> !$rose(parity_error);
  endproperty
  a_no_parity: assert property (p_no_parity) else $error("parity flag while off");
endmodule : ursc_top_monitor
bind ursc_top ursc_top_monitor #(.DATA_W(DATA_W)) i_mon (
  .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .rx_data(rx_data), .parity_error(parity_error),
  .framing_error(framing_error), .overrun_error(overrun_error),
  .data_received(data_received), .status_flags_oe(status_flags_oe),
  .tx_shift_empty(tx_shift_empty)
);

// file: verif/tb_uart_receiver_status_control.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the receiver status block
module tb_uart_receiver_status_control;
  `define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
  localparam int DIV = 4; // short divisor keeps frames brief
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_serial_in, parity_error, framing_error, overrun_error;
  logic data_received, tx_buffer_empty, status_flags_oe, tx_shift_empty;
  logic [7:0] rx_data;
  int failures = 0;
  int tests_run = 0;
  always #2.5 clk = ~clk;
  ursc_top #(.DIV_W(16), .DATA_W(8)) i_dut (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_serial_in(rx_serial_in), .rx_data(rx_data), .parity_error(parity_error),
    .framing_error(framing_error), .overrun_error(overrun_error),
    .data_received(data_received), .tx_buffer_empty(tx_buffer_empty),
    .status_flags_oe(status_flags_oe), .tx_shift_empty(tx_shift_empty)
  );
  // far station: sixteen ticks of DIV cycles per bit
  ursc_serial_station #(.BIT_CYC(16 * DIV)) i_station (.clk(clk), .line(rx_serial_in));
  // ==========================================================
  // bus master; an idle edge at the end avoids re-driving psel in one step
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    `CHK(pready, 1'b1)
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    `CHK(r, x)
    `CHK(e, xe)
  endtask : rd
  // ==========================================================
  // reset values, unmapped place, then the start-up master clear
  task automatic t_start();
    rd(8'h00, 32'h23, 1'b0);
    rd(8'h18, 32'h03, 1'b0);
    rd(8'h10, 32'h516, 1'b0);
    rd(8'h1c, 32'h0, 1'b1);
    wr(8'h10, DIV);
    wr(8'h14, DIV);
    wr(8'h00, 32'h63);
    wr(8'h00, 32'h23);
    repeat (18 * DIV + 8) @(posedge clk);
    `CHK(tx_shift_empty, 1'b1)
  endtask : t_start
  // every length, both parities, inhibit, stop lengths, bad parity, bad stop
  task automatic t_formats();
    logic [7:0] c [6] = '{8'h30, 8'h29, 8'h36, 8'h2b, 8'h23, 8'h31};
    logic [7:0] d [6] = '{8'h15, 8'h2a, 8'h5b, 8'hc3, 8'h7e, 8'h3f};
    int n;
    int h;
    for (int k = 0; k < 6; k++)
    begin
      n = 5 + c[k][0] + 2 * c[k][1];
      h = c[k][4] ? (n == 5 ? 3 : 4) : 2;
      wr(8'h00, {24'h0, c[k]});
      i_station.send(d[k], n, !c[k][2], c[k][3], k == 2 || k == 3, h, k == 4);
      `CHK(rx_data, d[k] & ((8'h01 << n) - 8'h01))
      `CHK(data_received, 1'b1)
      `CHK(parity_error, k == 3)
      `CHK(framing_error, k == 4)
      rd(8'h08, {25'h0, 3'b011, k == 3, k == 4, 2'b01}, 1'b0);
      wr(8'h04, 32'h1);
      repeat (2) @(posedge clk);
      `CHK(data_received, 1'b0)
    end
  endtask : t_formats
  // unread character overrun, then master clear keeps the buffer
  task automatic t_overrun_clear();
    int n;
    n = 0;
    wr(8'h00, 32'h23);
    i_station.send(8'h11, 8, 1'b1, 1'b0, 1'b0, 2, 1'b0);
    i_station.send(8'h22, 8, 1'b1, 1'b0, 1'b0, 2, 1'b1);
    `CHK(overrun_error, 1'b1)
    `CHK(rx_data, 8'h22)
    wr(8'h00, 32'h63);
    repeat (2) @(posedge clk);
    `CHK({parity_error, framing_error, overrun_error, data_received, tx_shift_empty}, 5'h00)
    `CHK(rx_data, 8'h22)
    wr(8'h00, 32'h23);
    while (tx_shift_empty !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    `CHK(n >= 17 * DIV - 1 && n <= 18 * DIV + 4, 1'b1)
  endtask : t_overrun_clear
  // pin release and format latching with load high and low
  task automatic t_pins_load();
    wr(8'h00, 32'ha3);
    `CHK(status_flags_oe, 1'b0)
    wr(8'h00, 32'h2b);
    `CHK(status_flags_oe, 1'b1)
    `CHK(tx_buffer_empty, 1'b1)
    rd(8'h18, 32'h0b, 1'b0);
    wr(8'h00, 32'h17);
    rd(8'h18, 32'h0b, 1'b0);
    wr(8'h00, 32'h23);
    rd(8'h18, 32'h03, 1'b0);
  endtask : t_pins_load
  // ==========================================================
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  // hang guard, well beyond the expected length of the run
  initial
  begin
    repeat (40000) @(posedge clk);
    failures++;
    summarize();
  end
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_start();
    t_formats();
    t_overrun_clear();
    t_pins_load();
    summarize();
  end
endmodule : tb_uart_receiver_status_control
